/* ssp_defines.svh */
/*
  Constants of the simple serial port: register indexes, bit positions, rates.
  Assumes inclusion by bare name from the top module and the bench.
*/
// Behaviour
// - Enable turns shared pins into serial pins
// - Disabling aborts, zeroes counter, frees pins
// - Bit order: 1 low first, 0 high first
// - Master data write starts a clocked transfer
// - Data pins behave alike in both modes
// - Master select writable; clearing aborts; reset slave
// - Flag reset write one clears done; reads zero
// - Drive on falling edge, capture on rising
// - Clock idle select: 1 low, 0 high
// - Rate select divides oscillator by 64..8
// - Done flag set on final rising edge
// - Done cleared by status-then-data access or reset bit
// - Cleared early, done sets again at end
// - Data access mid-transfer sets collision flag
// - Collision cleared by status-then-data access sequence
// - Late clearing access after start sets collision again
// - Single unbuffered data register, writes overwrite
// - Reset leaves data register unchanged
// - Reset clears enable, order and flags
// - Interrupt request while enabled and done set
// - Eight bits per transfer, ends on eighth capturing rise
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_IDX_SCR 6'h0a
`define SSP_IDX_SSR 6'h0b
`define SSP_IDX_SDR 6'h0c
`define SSP_B_IRQEN 7
`define SSP_B_EN 6
`define SSP_B_LOW_BIT_FIRST 5
`define SSP_B_MASTER_SELECT 4
`define SSP_B_FRST 3
`define SSP_B_IDLE 2
`define SSP_B_RATEHI 1
`define SSP_B_RATELO 0
`define SSP_B_DONE 7
`define SSP_B_COLL 6
`define SSP_DIV_00 7'h40
`define SSP_DIV_01 7'h20
`define SSP_DIV_10 7'h10
`define SSP_DIV_11 7'h08
`define SSP_LAST_BIT 3'h7
`define SSP_RATE_RST 2'h0
`endif

/* ssp_pkg.sv */
/*
  Types of the simple serial port: the packed state record.
  Assumes nothing from the defines header, which it does not include.
*/
`default_nettype none
package ssp_pkg;
  typedef struct packed {
    logic en;
    logic low_bit_first;
    logic master_select;
    logic idle_lo;
    logic [1:0] rate;
    logic irq_en;
    logic done;
    logic coll;
    logic arm;
    logic active;
    logic sck;
    logic fin;
    logic started;
    logic [2:0] bits;
    logic [4:0] div;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic di_s1;
    logic di_s2;
    logic serial_out_pin;
    logic [7:0] rd;
    logic pready;
    logic pslverr;
    logic irq;
    logic out_o;
    logic out_oe;
    logic in_o;
    logic in_oe;
    logic clk_o;
    logic clk_oe;
  } ssp_state_t;
endpackage
`default_nettype wire

/* ssp_top.sv */
/*
  Simple serial port: APB register slave, 8-bit shifter, master clock divider,
  slave clock edge detection and shared-pin muxing.
  Assumes pclk is the oscillator, pin inputs are asynchronous, gp_* come from
  port logic on pclk.
*/
`include "ssp_defines.svh"
`default_nettype none
module ssp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [2:0] gp_out,
  input wire logic [2:0] gp_oe,
  output logic pin_out_o,
  output logic pin_out_oe,
  input wire logic pin_in_i,
  output logic pin_in_o,
  output logic pin_in_oe,
  input wire logic pin_clk_i,
  output logic pin_clk_o,
  output logic pin_clk_oe
);
  import ssp_pkg::*;

  ssp_state_t s;
  ssp_state_t n;
  logic [7:0] data;
  logic [7:0] next_data;
  logic idle_lvl;
  logic tick;
  logic rise;
  logic fall;
  logic cap;
  logic done_evt;
  logic acc;
  logic hit;
  logic wr_scr;
  logic rd_ssr;
  logic sdr_acc;
  logic [4:0] half;
  logic clr_done;
  logic clr_coll;

  function automatic logic [4:0] half_of(input logic [1:0] r);
    logic [6:0] d;
    d = `SSP_DIV_00;
    case (r)
      2'h1: d = `SSP_DIV_01;
      2'h2: d = `SSP_DIV_10;
      2'h3: d = `SSP_DIV_11;
      default: d = `SSP_DIV_00;
    endcase
    return 5'((d >> 1) - 7'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    next_data = data;
    idle_lvl = ~s.idle_lo;
    half = half_of(s.rate);
    n.ck_s1 = pin_clk_i;
    n.ck_s2 = s.ck_s1;
    n.ck_s3 = s.ck_s2;
    n.di_s1 = pin_in_i;
    n.di_s2 = s.di_s1;
    // Master edges come from the divider, slave edges from the synced pin
    tick = s.active && (s.div == 5'h00);
    rise = 1'b0;
    fall = 1'b0;
    if (s.en && s.master_select) begin
      if (s.active) begin
        n.div = (s.div == 5'h00) ? half : 5'(s.div - 5'h01);
      end
      if (tick) begin
        if (s.fin && (s.sck == idle_lvl)) begin
          n.active = 1'b0;
          n.fin = 1'b0;
        end else begin
          n.sck = ~s.sck;
          rise = ~s.sck;
          fall = s.sck;
        end
      end
      if (!s.active) begin
        n.sck = idle_lvl;
      end
    end else if (s.en) begin
      rise = s.ck_s2 && !s.ck_s3;
      fall = !s.ck_s2 && s.ck_s3;
      if (s.fin && (s.ck_s2 == idle_lvl)) begin
        n.fin = 1'b0;
      end
      n.sck = idle_lvl;
    end else begin
      n.sck = idle_lvl;
    end
    // Same shifting in both modes; only the clock source differs
    cap = rise && s.started && !s.fin;
    done_evt = cap && (s.bits == `SSP_LAST_BIT);
    if (fall && !s.fin) begin
      n.serial_out_pin = s.low_bit_first ? data[0] : data[7];
      n.started = 1'b1;
    end
    if (cap) begin
      next_data = s.low_bit_first ? {s.di_s2, data[7:1]} : {data[6:0], s.di_s2};
      n.bits = 3'(s.bits + 3'h1);
    end
    if (done_evt) begin
      n.fin = 1'b1;
      n.started = 1'b0;
      n.bits = 3'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // APB: zero-wait access phase, error on unmapped index
    hit = (paddr[7:2] == `SSP_IDX_SCR) || (paddr[7:2] == `SSP_IDX_SSR) ||
          (paddr[7:2] == `SSP_IDX_SDR);
    acc = psel && penable && s.pready;
    wr_scr = acc && pwrite && (paddr[7:2] == `SSP_IDX_SCR);
    rd_ssr = acc && !pwrite && (paddr[7:2] == `SSP_IDX_SSR);
    sdr_acc = acc && (paddr[7:2] == `SSP_IDX_SDR);
    n.pready = psel && !penable;
    n.pslverr = psel && !penable && !hit;
    n.rd = 8'h00;
    if (psel && !penable) begin
      case (paddr[7:2])
        `SSP_IDX_SCR: begin
          n.rd[`SSP_B_IRQEN] = s.irq_en;
          n.rd[`SSP_B_EN] = s.en;
          n.rd[`SSP_B_LOW_BIT_FIRST] = s.low_bit_first;
          n.rd[`SSP_B_MASTER_SELECT] = s.master_select;
          n.rd[`SSP_B_IDLE] = s.idle_lo;
          n.rd[`SSP_B_RATEHI] = s.rate[1];
          n.rd[`SSP_B_RATELO] = s.rate[0];
        end
        `SSP_IDX_SSR: begin
          n.rd[`SSP_B_DONE] = s.done;
          n.rd[`SSP_B_COLL] = s.coll;
        end
        `SSP_IDX_SDR: n.rd = data;
        default: n.rd = 8'h00;
      endcase
    end
    if (wr_scr) begin
      n.irq_en = pwdata[`SSP_B_IRQEN];
      n.en = pwdata[`SSP_B_EN];
      n.low_bit_first = pwdata[`SSP_B_LOW_BIT_FIRST];
      n.master_select = pwdata[`SSP_B_MASTER_SELECT];
      n.idle_lo = pwdata[`SSP_B_IDLE];
      n.rate = {pwdata[`SSP_B_RATEHI], pwdata[`SSP_B_RATELO]};
    end
    if (sdr_acc && pwrite) begin
      next_data = pwdata[7:0];
      if (s.en && s.master_select && !s.active) begin
        n.active = 1'b1;
        n.div = half;
        n.fin = 1'b0;
        n.bits = 3'h0;
      end
    end
    ////////////////////////////////////////////////////////////////////////
    // Flags: clears first, then sets, so a same-cycle event is kept
    if (rd_ssr && s.done) begin
      n.arm = 1'b1;
    end
    clr_done = (sdr_acc && s.arm) || (wr_scr && pwdata[`SSP_B_FRST]);
    clr_coll = sdr_acc && s.arm;
    if (sdr_acc) begin
      n.arm = 1'b0;
    end
    if (clr_done) begin
      n.done = 1'b0;
    end
    if (clr_coll) begin
      n.coll = 1'b0;
    end
    if (done_evt) begin
      n.done = 1'b1;
    end
    if (sdr_acc && s.started) begin
      n.coll = 1'b1;
    end
    // Abort on disable or on leaving master mode
    if (!n.en || (s.master_select && !n.master_select)) begin
      n.active = 1'b0;
      n.bits = 3'h0;
      n.started = 1'b0;
      n.fin = 1'b0;
    end
    n.irq = n.irq_en && n.done;
    // Shared pins: port logic owns them whenever the serial port is off
    n.out_o = n.en ? n.serial_out_pin : gp_out[0];
    n.out_oe = n.en ? 1'b1 : gp_oe[0];
    n.in_o = gp_out[1];
    n.in_oe = n.en ? 1'b0 : gp_oe[1];
    n.clk_o = n.en ? (n.master_select ? n.sck : 1'b0) : gp_out[2];
    n.clk_oe = n.en ? n.master_select : gp_oe[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.sck <= 1'b1;
      s.rate <= `SSP_RATE_RST;
    end else begin
      s <= n;
    end
  end

  // Data register keeps its contents through reset
  always_ff @(posedge pclk) begin
    data <= next_data;
  end

  assign prdata = {24'h000000, s.rd};
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign pin_out_o = s.out_o;
  assign pin_out_oe = s.out_oe;
  assign pin_in_o = s.in_o;
  assign pin_in_oe = s.in_oe;
  assign pin_clk_o = s.clk_o;
  assign pin_clk_oe = s.clk_oe;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_abort_en;
    $fell(s.en) |-> (s.bits == 3'h0) && !s.active && !s.started;
  endproperty
  a_abort_en: assert property (p_abort_en) else $error("disable did not abort");

  property p_abort_master_select;
    $fell(s.master_select) |-> !s.active;
  endproperty
  a_abort_master_select: assert property (p_abort_master_select) else $error("master clear did not abort");

  property p_flag_reset;
    wr_scr && pwdata[`SSP_B_FRST] && !done_evt |=> !s.done;
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("flag reset write ignored");

  property p_scr_read;
    s.pready && !pwrite && (paddr[7:2] == `SSP_IDX_SCR) |-> !prdata[`SSP_B_FRST];
  endproperty
  a_scr_read: assert property (p_scr_read) else $error("flag reset bit read nonzero");

  property p_done_set;
    done_evt |=> s.done ##0 s.fin;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set at end");

  property p_eight;
    done_evt |-> $past(s.bits, 1) == 3'h6 || $past(cap) == 1'b0;
  endproperty
  a_eight: assert property (p_eight) else $error("transfer length not eight");

  property p_coll;
    sdr_acc && s.started |=> s.coll;
  endproperty
  a_coll: assert property (p_coll) else $error("collision not flagged");

  property p_irq;
    s.irq_en && s.done |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");

  property p_start;
    sdr_acc && pwrite && s.en && s.master_select && !s.active |=> s.active ##1 s.active;
  endproperty
  a_start: assert property (p_start) else $error("master transfer did not start");

  property p_idle;
    !s.active && $past(!s.active) && $stable(s.idle_lo) && s.en |-> s.sck == !s.idle_lo;
  endproperty
  a_idle: assert property (p_idle) else $error("clock not at idle level");

  property p_pins;
    s.en |-> pin_out_oe && !pin_in_oe && (pin_clk_oe == s.master_select);
  endproperty
  a_pins: assert property (p_pins) else $error("serial pin directions wrong");

endmodule
`default_nettype wire

/* ssp_peer.sv */
/*
  Link peer model: shifts one byte against the port each frame.
  Assumes the port is master and drives the serial clock.
*/
`default_nettype none
module ssp_peer (
  input wire logic sck,
  input wire logic dout,
  input wire logic low_bit_first,
  input wire logic load,
  input wire logic [7:0] tx,
  output logic din,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic seen_fall;
  initial begin
    din = 1'b0;
    seen_fall = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge load) begin
    sh = tx;
    seen_fall = 1'b0;
  end
  // Refill with inverted bits so stray edges never show a held value
  always @(negedge sck) begin
    din = low_bit_first ? sh[0] : sh[7];
    sh = low_bit_first ? {~sh[0], sh[7:1]} : {sh[6:0], ~sh[7]};
    seen_fall = 1'b1;
  end
  // A leading rise at idle low carries no data
  always @(posedge sck) begin
    if (seen_fall) begin
      rx = low_bit_first ? {dout, rx[7:1]} : {rx[6:0], dout};
    end
  end
endmodule
`default_nettype wire

/* simple_serial_port_tb_top.sv */
/*
  Bench for the serial port: APB master, link peer, random bytes.
  Assumes zero-wait APB answers and the port as link master.
*/
`include "ssp_defines.svh"
`default_nettype none
module simple_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, load = 1'b0;
  logic [7:0] paddr = 8'h00, tx = 8'h00, rd, peer_rx, cfg = 8'h00, mid;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] gp_out = 3'h0, gp_oe = 3'h0;
  logic pready, pslverr, irq, out_o, out_oe, in_o, in_oe, clk_o, clk_oe, din, err;
  int num_errors = 0, samples_checked = 0, seed = 70297;
  realtime t_fall = 0, period = 0;
  always #2.5 pclk = ~pclk;
  ssp_top u_ssp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .gp_out(gp_out), .gp_oe(gp_oe), .pin_out_o(out_o), .pin_out_oe(out_oe), .pin_in_i(din),
    .pin_in_o(in_o), .pin_in_oe(in_oe), .pin_clk_i(clk_o), .pin_clk_o(clk_o), .pin_clk_oe(clk_oe));
  ssp_peer u_ssp_peer (.sck(clk_o), .dout(out_o), .low_bit_first(cfg[`SSP_B_LOW_BIT_FIRST]), .load(load), .tx(tx),
    .din(din), .rx(peer_rx));
  always @(negedge clk_o) begin
    period = $realtime - t_fall;
    t_fall = $realtime;
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until pready is seen at a rising edge, for at most 50 edges
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    rd = 8'h00;
    for (int i = 0; i < 3000 && rd[`SSP_B_DONE] !== 1'b1; i++) apb(1'b0, `SSP_IDX_SSR, 8'h00);
  endtask
  task automatic xfer(input logic [7:0] c);
    cfg = c;
    tx = $random(seed);
    apb(1'b1, `SSP_IDX_SCR, c);
    // Let the idle level settle on the pin so the peer sees no stray fall
    repeat (2) @(posedge pclk);
    load <= 1'b1;
    mid = $random(seed);
    apb(1'b1, `SSP_IDX_SDR, mid);
    load <= 1'b0;
  endtask
  initial begin
    #300us;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SSP_IDX_SCR, 8'h00);
    chk("control reset", 8'h00, rd);
    apb(1'b0, `SSP_IDX_SSR, 8'h00);
    chk("status reset", 8'h00, rd);
    apb(1'b1, 6'h3f, 8'hff);
    chk("unmapped error", 1'b1, err);
    apb(1'b1, `SSP_IDX_SDR, 8'ha5);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SSP_IDX_SDR, 8'h00);
    chk("data kept", 8'ha5, rd);
    // Abort mid-frame; the next frames show the bit counter restarted
    xfer(8'h53);
    repeat (12) @(posedge pclk);
    apb(1'b1, `SSP_IDX_SCR, 8'h13);
    gp_out <= $random(seed);
    gp_oe <= $random(seed);
    repeat (40) @(posedge pclk);
    chk("pins freed", {gp_out, gp_oe}, {clk_o, in_o, out_o, clk_oe, in_oe, out_oe});
    apb(1'b0, `SSP_IDX_SSR, 8'h00);
    chk("no done", 8'h00, rd);
    for (int i = 0; i < 16; i++) begin
      gp_out <= $random(seed);
      gp_oe <= $random(seed);
      xfer({i[0], 1'b1, i[3], 1'b1, 1'b0, i[2], i[1:0]});
      wait_done();
      chk("done", 1'b1, rd[`SSP_B_DONE]);
      chk("irq", cfg[7], irq);
      // Idle-low frames end one half period later; wait until the port is idle
      repeat (80) @(posedge pclk);
      chk("clock idle", !cfg[2], clk_o);
      chk("clock drive", 1'b1, clk_oe);
      chk("data dirs", 2'b01, {in_oe, out_oe});
      chk("sck period", 8'd64 >> cfg[1:0], period / 5.0);
      chk("peer got", mid, peer_rx);
      apb(1'b0, `SSP_IDX_SDR, 8'h00);
      chk("received", tx, rd);
      apb(1'b0, `SSP_IDX_SSR, 8'h00);
      chk("done cleared", 8'h00, rd);
    end
    xfer(8'h53);
    repeat (12) @(posedge pclk);
    apb(1'b1, `SSP_IDX_SDR, 8'h00);
    wait_done();
    chk("collision", 2'b11, rd[7:6]);
    apb(1'b1, `SSP_IDX_SCR, 8'h5b);
    apb(1'b0, `SSP_IDX_SCR, 8'h00);
    chk("control readback", 8'h53, rd);
    apb(1'b0, `SSP_IDX_SSR, 8'h00);
    chk("flag reset", 2'b01, rd[7:6]);
    apb(1'b0, `SSP_IDX_SDR, 8'h00);
    apb(1'b0, `SSP_IDX_SSR, 8'h00);
    chk("collision cleared", 2'b00, rd[7:6]);
    complete_run();
  end
endmodule
`default_nettype wire
